// file: rtl/sriov_cfg_map.svh
`ifndef SRIOV_CFG_MAP_SVH
`define SRIOV_CFG_MAP_SVH

`define APB_ADDR_W      12
`define APB_DATA_W      32
`define REQ_ADDR_W      64
`define SLOT_IDX_W      3
`define SIZE_LOG2_W     6
`define PSTATE_W        3

`define EP_SLOTS        6
`define RP_SLOTS        2
`define SIXTH_SLOT      5
`define PSTATE_COUNT    5

`define OFF_GLOBAL_CTRL 12'h000
`define OFF_STATUS      12'h004
`define OFF_SERIAL_LO   12'h008
`define OFF_SERIAL_HI   12'h00C
`define OFF_DROP_COUNT  12'h010
`define OFF_BASE0       12'h020
`define OFF_CFG0        12'h040
`define SLOT_STRIDE     12'h004

`define GC_ROOT_PORT    0
`define GC_LEGACY       1
`define GC_ECRC_EN      2
`define GC_DSN_EN       3
`define GC_VC_EN        4
`define GC_VSEC_EN      5
`define GC_SNOOP_REJ    6
`define GC_SRIOV_EN     7
`define GC_ARI_EN       8
`define GC_MSIX_EN      9
`define GC_TBL_LSB      10
`define GC_PBA_LSB      13
`define GC_WAKE_LSB     16
`define GC_USED_W       21
`define GC_RESET        21'h000000

`define ST_ACTIVE_LSB   0
`define ST_REJECT_LSB   6
`define ST_SMALL_LSB    12
`define ST_TBL_ERR      18
`define ST_PBA_ERR      19
`define ST_NO_MEM_WIN   20
`define ST_ARI          21
`define ST_VC           22
`define ST_VSEC         23
`define ST_AER          24

`define CFG_USED_W      10
`define CFG_RESET       10'h000
`define BASE_RESET      32'h00000000

`define MIN_MEM_STD_LOG2    6'h07
`define MIN_MEM_LEGACY_LOG2 6'h04
`define MIN_IO_LOG2         6'h04
`define MAX_32_LOG2         6'h1F
`define MAX_64_LOG2         6'h26
`define REC_MEM_LOG2        6'h0C
`define AER_CAP_OFFSET      12'h100

`endif

// file: rtl/sriov_cfg_pkg.sv
package sriov_cfg_pkg;
  `include "sriov_cfg_map.svh"

  typedef struct packed {
    logic [`REQ_ADDR_W-1:0] addr;
    logic                   is_io;
    logic                   ecrc_err;
    logic                   ns_applies;
    logic                   ns_set;
    logic                   func;
  } req_type;

  typedef struct packed {
    logic                   hit;
    logic [`SLOT_IDX_W-1:0] slot;
    logic                   drop;
    logic                   unsupported;
    logic                   merge_ok;
  } resp_type;

  typedef struct packed {
    logic [`SIZE_LOG2_W-1:0] size_log2;
    logic                    prefetch;
    logic                    is64;
    logic                    io;
    logic                    en;
  } win_cfg_type;

  typedef struct packed {
    logic aer_present;
    logic dsn_present;
    logic vc_first_physical_function;
    logic vsec_present;
    logic alternative_requester_id;
    logic ecrc_check;
  } cap_type;
endpackage

// file: rtl/window_match.sv
`timescale 1ns/100ps
module window_match
  import sriov_cfg_pkg::*;
(
  input  wire logic                   active,   // Window legal and enabled
  input  wire win_cfg_type            cfg,      // Window configuration
  input  wire logic [`REQ_ADDR_W-1:0] base,     // Full base address
  input  wire req_type                req,      // Incoming request
  output      logic                   hit       // Request falls in window
);
  logic [`REQ_ADDR_W-1:0] mask;
  logic                   wide;

  // Bits below the power-of-two size are don't-care in the compare.
  assign mask = {`REQ_ADDR_W{1'b1}} << cfg.size_log2;
  assign wide = cfg.is64 & ~cfg.io;

  always_comb begin
    hit = active & (req.is_io == cfg.io);
    if (((req.addr ^ base) & mask) != {`REQ_ADDR_W{1'b0}}) begin
      hit = 1'b0;
    end
    // A 32-bit window can never claim an address above 4 GB.
    if (!wide && req.addr[`REQ_ADDR_W-1:32] != 32'h00000000) begin
      hit = 1'b0;
    end
  end
endmodule

// file: rtl/sriov_window_cfg.sv
// Behaviour
// - Endpoint offers up to six 32-bit windows or three 64-bit windows.
// - Root port offers up to two 32-bit windows or one 64-bit window.
// - A 64-bit window takes the next slot for its upper half; that slot is dead.
// - I/O windows are 32-bit, never prefetchable, legacy endpoint only.
// - Minimum memory window 128 bytes standard, 16 bytes legacy.
// - 32-bit windows up to 2 GB, 64-bit windows up to 256 GB.
// - I/O windows below 16 bytes are refused.
// - A window claims only requests of its own space type.
// - Memory windows below 4 KB are flagged as discouraged, not refused.
// - Non-legacy prefetchable windows must be 64-bit, except the sixth slot.
// - Prefetchable windows may merge byte writes into a doubleword write.
// - Error reporting capability always present at extended offset 100 hex.
// - With ECRC checking on, packets with ECRC errors are dropped.
// - Virtual channel and vendor capabilities need the serial number capability.
// - Virtual channel capability exists for the first physical function only.
// - Root port may reject unset no-snoop requests as unsupported.
// - An MSI-X indicator naming a 64-bit window means its lower slot.
// - Wake request is raised only in power states enabled for wake.
// - Virtualization support forces the alternative requester ID capability on.
//
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/100ps
module sriov_window_cfg
  import sriov_cfg_pkg::*;
#(
  parameter int NUM_SLOTS = `EP_SLOTS
)(
  input  wire logic                   pclk,               // Core clock
  input  wire logic                   presetn,            // Async reset, active low
  input  wire logic                   psel,               // APB select
  input  wire logic                   penable,            // APB access phase
  input  wire logic                   pwrite,             // APB write
  input  wire logic [`APB_ADDR_W-1:0] paddr,              // APB byte address
  input  wire logic [`APB_DATA_W-1:0] pwdata,             // APB write data
  input  wire logic [3:0]             pstrb,              // APB byte strobes
  output      logic [`APB_DATA_W-1:0] prdata,             // APB read data
  output      logic                   pready,             // APB ready
  output      logic                   pslverr,            // APB error
  input  wire logic                   req_valid,          // Request present
  input  wire req_type                req,                // Request header
  output      logic                   resp_valid,         // Decision present
  output      resp_type               resp,               // Decision
  input  wire logic [63:0]            serial_number,      // Device serial number
  input  wire logic                   wake_request_in,    // Function wants wake
  input  wire logic [`PSTATE_W-1:0]   power_state,        // Current power state
  output      logic                   power_wake_request, // Wake toward the link
  output      cap_type                caps,               // Capability presence
  output      logic [11:0]            aer_cap_offset      // Error capability offset
);
  if (NUM_SLOTS < `RP_SLOTS || NUM_SLOTS > `EP_SLOTS) begin : g_bad_slots
    $error("NUM_SLOTS must lie between two and six");
  end

  logic [`GC_USED_W-1:0]  gctrl_reg;
  logic [`CFG_USED_W-1:0] cfg_reg  [NUM_SLOTS];
  logic [31:0]            base_reg [NUM_SLOTS];
  logic [31:0]            drop_count_reg;

  logic wr_en;
  logic rd_en;
  logic root_port;
  logic legacy;
  logic [`SLOT_IDX_W-1:0] tbl_bir;
  logic [`SLOT_IDX_W-1:0] pba_bir;
  logic [`PSTATE_COUNT-1:0] wake_mask;

  logic [NUM_SLOTS-1:0] active;
  logic [NUM_SLOTS-1:0] rejected;
  logic [NUM_SLOTS-1:0] small_win;
  logic [NUM_SLOTS-1:0] win64;
  logic [NUM_SLOTS-1:0] upper_taken;
  logic [NUM_SLOTS-1:0] is_mem;
  logic [NUM_SLOTS-1:0] pf_eff;
  logic [NUM_SLOTS-1:0] hits;
  logic [`SLOT_IDX_W-1:0] max_slots;

  assign wr_en     = psel & penable & pwrite;
  assign rd_en     = psel & penable & ~pwrite;
  assign pready    = 1'b1;
  assign root_port = gctrl_reg[`GC_ROOT_PORT];
  assign legacy    = gctrl_reg[`GC_LEGACY] & ~root_port;
  assign tbl_bir   = gctrl_reg[`GC_TBL_LSB +: `SLOT_IDX_W];
  assign pba_bir   = gctrl_reg[`GC_PBA_LSB +: `SLOT_IDX_W];
  assign wake_mask = gctrl_reg[`GC_WAKE_LSB +: `PSTATE_COUNT];
  // Root port exposes only the first two slots.
  assign max_slots = root_port ? `SLOT_IDX_W'(`RP_SLOTS)
                               : `SLOT_IDX_W'(NUM_SLOTS);

  function automatic logic [31:0] merge_bytes(input logic [31:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return r;
  endfunction

  logic [31:0] gctrl_next;

  assign gctrl_next = merge_bytes(32'(gctrl_reg), pwdata, pstrb);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gctrl_reg <= `GC_RESET;
    end else if (wr_en && paddr == `OFF_GLOBAL_CTRL) begin
      gctrl_reg <= gctrl_next[`GC_USED_W-1:0];
    end
  end

  genvar i;
  for (i = 0; i < NUM_SLOTS; i++) begin : g_slot
    localparam logic [`APB_ADDR_W-1:0] BASE_ADDR =
      `APB_ADDR_W'(`OFF_BASE0 + i * `SLOT_STRIDE);
    localparam logic [`APB_ADDR_W-1:0] CFG_ADDR =
      `APB_ADDR_W'(`OFF_CFG0 + i * `SLOT_STRIDE);
    win_cfg_type             c;
    logic                    io_eff;
    logic                    wide;
    logic                    slot_ok;
    logic                    pair_ok;
    logic                    io_ok;
    logic                    size_ok;
    logic                    pf_ok;
    logic [`SIZE_LOG2_W-1:0] min_log2;
    logic [`SIZE_LOG2_W-1:0] max_log2;
    logic [`REQ_ADDR_W-1:0]  base_full;
    logic [31:0]             cfg_next;

    assign cfg_next = merge_bytes(32'(cfg_reg[i]), pwdata, pstrb);

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cfg_reg[i] <= `CFG_RESET;
      end else if (wr_en && paddr == CFG_ADDR) begin
        cfg_reg[i] <= cfg_next[`CFG_USED_W-1:0];
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        base_reg[i] <= `BASE_RESET;
      end else if (wr_en && paddr == BASE_ADDR) begin
        base_reg[i] <= merge_bytes(base_reg[i], pwdata, pstrb);
      end
    end

    assign c       = win_cfg_type'(cfg_reg[i]);
    assign io_eff  = c.io;
    // I/O windows are forced to 32 bits and never prefetch.
    assign wide    = c.is64 & ~io_eff;
    assign pf_eff[i] = c.prefetch & ~io_eff;
    assign is_mem[i] = ~io_eff;
    assign slot_ok = `SLOT_IDX_W'(i) < max_slots;
    // The upper half needs a slot of its own inside the allowed range.
    assign pair_ok = ~wide | (`SLOT_IDX_W'(i + 1) < max_slots);
    assign io_ok   = ~io_eff | legacy;
    assign min_log2 = io_eff ? `MIN_IO_LOG2 :
                      legacy ? `MIN_MEM_LEGACY_LOG2 : `MIN_MEM_STD_LOG2;
    assign max_log2 = wide ? `MAX_64_LOG2 : `MAX_32_LOG2;
    assign size_ok = (c.size_log2 >= min_log2) && (c.size_log2 <= max_log2);
    assign pf_ok   = legacy | ~pf_eff[i] | wide | (i == `SIXTH_SLOT);
    if (i == 0) begin : g_first
      assign upper_taken[i] = 1'b0;
    end else begin : g_rest
      assign upper_taken[i] = win64[i-1];
    end
    assign active[i]    = c.en & slot_ok & ~upper_taken[i] & pair_ok & io_ok
                        & size_ok & pf_ok;
    assign rejected[i]  = c.en & ~active[i];
    assign win64[i]     = active[i] & wide;
    assign small_win[i] = active[i] & ~io_eff & (c.size_log2 < `REC_MEM_LOG2);
    if (i + 1 < NUM_SLOTS) begin : g_hi
      assign base_full = wide ? {base_reg[i+1], base_reg[i]}
                              : {32'h00000000, base_reg[i]};
    end else begin : g_nohi
      assign base_full = {32'h00000000, base_reg[i]};
    end

    window_match u_match (
      .active (active[i]),
      .cfg    (c),
      .base   (base_full),
      .req    (req),
      .hit    (hits[i])
    );
  end

  // MSI-X indicators must name an active memory window; a 64-bit window is
  // named by its lower slot, so naming the dead upper slot is an error.
  logic tbl_ok;
  logic pba_ok;
  logic tbl_err;
  logic pba_err;
  logic no_mem_win;

  always_comb begin
    tbl_ok = 1'b0;
    pba_ok = 1'b0;
    if (tbl_bir < `SLOT_IDX_W'(NUM_SLOTS)) begin
      tbl_ok = active[tbl_bir] & is_mem[tbl_bir] & ~upper_taken[tbl_bir];
    end
    if (pba_bir < `SLOT_IDX_W'(NUM_SLOTS)) begin
      pba_ok = active[pba_bir] & is_mem[pba_bir] & ~upper_taken[pba_bir];
    end
  end

  assign tbl_err    = gctrl_reg[`GC_MSIX_EN] & ~tbl_ok;
  assign pba_err    = gctrl_reg[`GC_MSIX_EN] & ~pba_ok;
  assign no_mem_win = gctrl_reg[`GC_MSIX_EN] & ~|(active & is_mem);

  // Lowest slot wins should two windows overlap; software is expected to
  // keep them apart, and a fixed order keeps the answer repeatable.
  logic                   any_hit;
  logic [`SLOT_IDX_W-1:0] hit_slot;

  always_comb begin
    any_hit  = 1'b0;
    hit_slot = '0;
    for (int s = NUM_SLOTS - 1; s >= 0; s--) begin
      if (hits[s]) begin
        any_hit  = 1'b1;
        hit_slot = `SLOT_IDX_W'(s);
      end
    end
  end

  logic drop_now;
  logic unsup_now;

  assign drop_now  = gctrl_reg[`GC_ECRC_EN] & req.ecrc_err;
  assign unsup_now = ~drop_now & root_port & gctrl_reg[`GC_SNOOP_REJ]
                   & req.ns_applies & ~req.ns_set;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resp_valid <= 1'b0;
    end else begin
      resp_valid <= req_valid;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resp <= '0;
    end else if (req_valid) begin
      // A dropped packet claims no window, so nothing reaches user logic.
      resp.hit         <= any_hit & ~drop_now & ~unsup_now;
      resp.slot        <= hit_slot;
      resp.drop        <= drop_now;
      resp.unsupported <= unsup_now;
      resp.merge_ok    <= any_hit & ~drop_now & ~unsup_now & pf_eff[hit_slot];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drop_count_reg <= 32'h00000000;
    end else if (req_valid && drop_now) begin
      drop_count_reg <= drop_count_reg + 32'h00000001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_wake_request <= 1'b0;
    end else if (power_state < `PSTATE_W'(`PSTATE_COUNT)) begin
      power_wake_request <= wake_request_in & wake_mask[power_state];
    end else begin
      power_wake_request <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      caps <= '0;
    end else begin
      caps.aer_present                <= 1'b1;
      caps.dsn_present                <= gctrl_reg[`GC_DSN_EN];
      // Only the first physical function carries the virtual channel.
      caps.vc_first_physical_function <= gctrl_reg[`GC_VC_EN]
                                       & gctrl_reg[`GC_DSN_EN];
      caps.vsec_present               <= gctrl_reg[`GC_VSEC_EN]
                                       & gctrl_reg[`GC_DSN_EN];
      caps.alternative_requester_id   <= gctrl_reg[`GC_ARI_EN]
                                       | gctrl_reg[`GC_SRIOV_EN];
      caps.ecrc_check                 <= gctrl_reg[`GC_ECRC_EN];
    end
  end

  assign aer_cap_offset = `AER_CAP_OFFSET;

  logic [31:0] status;
  logic [31:0] rd_data;
  logic        rd_hit;

  always_comb begin
    status = 32'h00000000;
    status[`ST_ACTIVE_LSB +: NUM_SLOTS] = active;
    status[`ST_REJECT_LSB +: NUM_SLOTS] = rejected;
    status[`ST_SMALL_LSB +: NUM_SLOTS]  = small_win;
    status[`ST_TBL_ERR]    = tbl_err;
    status[`ST_PBA_ERR]    = pba_err;
    status[`ST_NO_MEM_WIN] = no_mem_win;
    status[`ST_ARI]        = caps.alternative_requester_id;
    status[`ST_VC]         = caps.vc_first_physical_function;
    status[`ST_VSEC]       = caps.vsec_present;
    status[`ST_AER]        = caps.aer_present;
  end

  always_comb begin
    rd_data = 32'h00000000;
    rd_hit  = 1'b1;
    unique case (paddr)
      `OFF_GLOBAL_CTRL: rd_data = 32'(gctrl_reg);
      `OFF_STATUS:      rd_data = status;
      `OFF_SERIAL_LO:   rd_data = serial_number[31:0];
      `OFF_SERIAL_HI:   rd_data = serial_number[63:32];
      `OFF_DROP_COUNT:  rd_data = drop_count_reg;
      default: begin
        rd_hit = 1'b0;
        for (int s = 0; s < NUM_SLOTS; s++) begin
          if (paddr == `APB_ADDR_W'(`OFF_BASE0 + s * `SLOT_STRIDE)) begin
            rd_data = base_reg[s];
            rd_hit  = 1'b1;
          end
          if (paddr == `APB_ADDR_W'(`OFF_CFG0 + s * `SLOT_STRIDE)) begin
            rd_data = 32'(cfg_reg[s]);
            rd_hit  = 1'b1;
          end
        end
      end
    endcase
  end

  // Read data is captured into a flop so the bus sees a stable value.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_data;
    end
  end

  assign pslverr = psel & penable & ~rd_hit;
endmodule

// file: testbench/sriov_window_cfg_sva.sv
`timescale 1ns/100ps
module sriov_window_cfg_sva
  import sriov_cfg_pkg::*;
#(
  parameter int NUM_SLOTS = 6
)(
  input wire logic        pclk,               // Clock
  input wire logic        presetn,            // Reset
  input wire logic        psel,               // Select
  input wire logic        penable,            // Access phase
  input wire logic        pwrite,             // Write
  input wire logic [11:0] paddr,              // Address
  input wire logic [31:0] pwdata,             // Write data
  input wire logic [3:0]  pstrb,              // Strobes
  input wire logic [31:0] prdata,             // Read data
  input wire logic        pready,             // Ready
  input wire logic        pslverr,            // Error
  input wire logic        req_valid,          // Request strobe
  input wire req_type     req,                // Request
  input wire logic        resp_valid,         // Decision strobe
  input wire resp_type    resp,               // Decision
  input wire logic [63:0] serial_number,      // Serial number
  input wire logic        wake_request_in,    // Wake wish
  input wire logic [2:0]  power_state,        // Power state
  input wire logic        power_wake_request, // Wake out
  input wire cap_type     caps,               // Capabilities
  input wire logic [11:0] aer_cap_offset      // Error cap offset
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_resp_follow: assert property (req_valid |=> resp_valid)
    else $error("request without a decision one cycle later");
  chk_resp_hold: assert property (!req_valid |=> $stable(resp))
    else $error("decision changed without a request");
  chk_ecrc_drop: assert property (req_valid && req.ecrc_err ##1 caps.ecrc_check
    |-> resp.drop && !resp.hit) else $error("corrupt packet not dropped");
  chk_drop_clean: assert property (resp_valid && resp.drop
    |-> !resp.hit && !resp.unsupported && !resp.merge_ok) else $error("dropped packet claimed");
  chk_merge_hit: assert property (resp_valid && resp.merge_ok
    |-> resp.hit && resp.slot < NUM_SLOTS) else $error("merge without a window hit");
  chk_snoop_cause: assert property (resp_valid && resp.unsupported
    |-> $past(req.ns_applies && !req.ns_set)) else $error("unsupported without snoop cause");
  chk_aer_fixed: assert property ($past(presetn)
    |-> caps.aer_present && aer_cap_offset == 12'h100) else $error("error capability missing");
  chk_vc_needs_dsn: assert property (caps.vc_first_physical_function || caps.vsec_present
    |-> caps.dsn_present) else $error("channel capability without serial number");
  chk_wake_state: assert property (power_wake_request
    |-> $past(wake_request_in) && $past(power_state) < 3'h5) else $error("wake in wrong state");
  chk_err_access: assert property (pslverr
    |-> psel && penable && pready && !(paddr < 12'h014 && paddr[1:0] == 2'h0))
    else $error("slave error outside access phase or on a mapped register");

  cover property (resp_valid && resp.drop);
  cover property (resp_valid && resp.merge_ok);
  cover property (resp_valid && resp.unsupported);
  cover property (power_wake_request);
endmodule

bind sriov_window_cfg sriov_window_cfg_sva #(.NUM_SLOTS(NUM_SLOTS)) chk_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .req_valid(req_valid), .req(req), .resp_valid(resp_valid),
  .resp(resp), .serial_number(serial_number), .wake_request_in(wake_request_in),
  .power_state(power_state), .power_wake_request(power_wake_request), .caps(caps),
  .aer_cap_offset(aer_cap_offset)
);

// file: testbench/link_partner.sv
`timescale 1ns/100ps
module link_partner
  import sriov_cfg_pkg::*;
#(
  parameter logic [63:0] SERIAL = 64'h0123_4567_89AB_CDEF
)(
  input  wire logic        clk,           // Clock
  output      logic        req_valid,     // Request strobe
  output      req_type     req,           // Request header
  input  wire logic        resp_valid,    // Decision strobe
  input  wire resp_type    resp,          // Decision
  output      logic [63:0] serial_number  // Serial number
);
  assign serial_number = SERIAL;
  initial begin
    req_valid = 1'b0;
    req = '0;
  end
  // The header is inverted once released so a stale value never passes for a live one.
  task automatic send(input req_type h, output logic v, output logic [6:0] r);
    @(posedge clk);
    req_valid <= 1'b1;
    req       <= h;
    @(posedge clk);
    req_valid <= 1'b0;
    req       <= ~h;
    @(negedge clk);
    v = resp_valid;
    r = resp;
  endtask
endmodule

// file: testbench/testbench.sv
`timescale 1ns/100ps
module testbench;
  import sriov_cfg_pkg::*;
  localparam logic [63:0] SER = 64'h0123_4567_89AB_CDEF;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        req_valid;
  logic        resp_valid;
  logic        wake_in = 1'b0;
  logic [2:0]  pstate = '0;
  logic        wake_out;
  logic [63:0] serial;
  logic [11:0] aer_off;
  req_type     req;
  resp_type    resp;
  cap_type     caps;
  int          bad_count = 0;
  int          n_compared = 0;
  int          cycles = 0;
  logic [31:0] rd;
  logic        err;
  logic        v;
  logic [6:0]  r;
  logic [7:0]  cg [4] = '{8'h30, 8'h38, 8'h80, 8'h04};
  logic [5:0]  ce [4] = '{6'h20, 6'h3C, 6'h22, 6'h21};

  always #4 pclk = ~pclk;

  sriov_window_cfg #(.NUM_SLOTS(6)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .req_valid(req_valid), .req(req), .resp_valid(resp_valid),
    .resp(resp), .serial_number(serial), .wake_request_in(wake_in),
    .power_state(pstate), .power_wake_request(wake_out), .caps(caps),
    .aer_cap_offset(aer_off)
  );

  link_partner #(.SERIAL(SER)) pm_u (
    .clk(pclk), .req_valid(req_valid), .req(req), .resp_valid(resp_valid),
    .resp(resp), .serial_number(serial)
  );

  task automatic close_out();
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      bad_count++;
      close_out();
    end
  end

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // The wait ends once pready reads 1; the bench timeout catches a stuck slave.
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input string name, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(name, exp, rd);
  endtask

  function automatic req_type mk(input logic [63:0] a, input logic io, e, na, ns);
    mk = {a, io, e, na, ns, 1'b0};
  endfunction

  function automatic logic [31:0] cw(input logic [5:0] s, input logic pf, w, io);
    cw = {22'h0, s, pf, w, io, 1'b1};
  endfunction

  task automatic rq(input string name, input req_type h, input logic [6:0] exp);
    pm_u.send(h, v, r);
    check(name, {24'h0, 1'b1, exp}, {24'h0, v, r});
  endtask

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rchk("ctrl", 12'h000, 32'h0);
    rchk("base3", 12'h02C, 32'h0);
    rchk("cfg3", 12'h04C, 32'h0);
    rchk("status", 12'h004, 32'h0100_0000);
    check("aer offset", 32'h100, {20'h0, aer_off});
    rchk("unmapped", 12'h0FC, 32'h0);
    check("unmapped err", 32'h1, {31'h0, err});
    check("ready", 32'h1, {31'h0, pready});
    // Slot 1 is a 64-bit window whose upper half sits in slot 2.
    apb(1'b1, 12'h020, 32'h0001_0000);
    apb(1'b1, 12'h040, cw(6'h0C, 0, 0, 0));
    apb(1'b1, 12'h024, 32'h0010_0000);
    apb(1'b1, 12'h028, 32'h0000_0002);
    apb(1'b1, 12'h044, cw(6'h14, 1, 1, 0));
    apb(1'b1, 12'h048, cw(6'h0C, 0, 0, 0));
    apb(1'b1, 12'h02C, 32'h0000_5000);
    apb(1'b1, 12'h04C, cw(6'h0C, 1, 0, 0));
    apb(1'b1, 12'h050, cw(6'h06, 0, 0, 0));
    apb(1'b1, 12'h034, 32'h0000_0300);
    apb(1'b1, 12'h054, cw(6'h08, 1, 0, 0));
    rchk("ep status", 12'h004, 32'h0102_0723);
    rq("ep top 0", mk(64'h1_0FFC, 0, 0, 0, 0), 7'h40);
    rq("ep past 0", mk(64'h1_1000, 0, 0, 0, 0), 7'h00);
    rq("ep io", mk(64'h1_0004, 1, 0, 0, 0), 7'h00);
    rq("ep wide", mk(64'h2_0010_0ABC, 0, 0, 0, 0), 7'h49);
    rq("ep wide low", mk(64'h0010_0ABC, 0, 0, 0, 0), 7'h00);
    rq("ep slot5", mk(64'h3FF, 0, 0, 0, 0), 7'h69);
    apb(1'b1, 12'h000, 32'h0000_0002);
    apb(1'b1, 12'h040, cw(6'h04, 0, 0, 1));
    apb(1'b1, 12'h050, cw(6'h03, 0, 0, 1));
    rchk("leg status", 12'h004, 32'h0102_052B);
    rq("leg io", mk(64'h1_000F, 1, 0, 0, 0), 7'h40);
    rq("leg mem", mk(64'h1_0000, 0, 0, 0, 0), 7'h00);
    apb(1'b1, 12'h040, cw(6'h0C, 0, 0, 0));
    apb(1'b1, 12'h000, 32'h0000_0045);
    rchk("rp status", 12'h004, 32'h0100_0F81);
    rq("rp snoop", mk(64'h1_0010, 0, 0, 1, 0), 7'h02);
    rq("rp snoop set", mk(64'h1_0010, 0, 0, 1, 1), 7'h40);
    rq("rp ecrc", mk(64'h1_0010, 0, 1, 1, 0), 7'h04);
    rchk("drops", 12'h010, 32'h1);
    apb(1'b1, 12'h000, 32'h0000_2A00);
    apb(1'b0, 12'h004, 32'h0);
    check("msix upper", 32'h1, {29'h0, rd[20:18]});
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, 12'h040 + 12'(4 * i), 32'h0);
    end
    apb(1'b1, 12'h000, 32'h0000_2600);
    apb(1'b0, 12'h004, 32'h0);
    check("msix none", 32'h7, {29'h0, rd[20:18]});
    foreach (cg[i]) begin
      apb(1'b1, 12'h000, {24'h0, cg[i]});
      @(posedge pclk);
      @(negedge pclk);
      check("caps", {26'h0, ce[i]}, {26'h0, caps});
    end
    rchk("serial lo", 12'h008, SER[31:0]);
    rchk("serial hi", 12'h00C, SER[63:32]);
    apb(1'b1, 12'h000, 32'h000A_0000);
    wake_in <= 1'b1;
    for (int s = 0; s < 8; s++) begin
      @(posedge pclk);
      pstate <= 3'(s);
      @(posedge pclk);
      @(negedge pclk);
      check("wake", {31'h0, s == 1 || s == 3}, {31'h0, wake_out});
    end
    close_out();
  end
endmodule
